// ==== include/clock_power_consts.vh ====
// Register map, field layout, reset values and timing of clock/power control
`ifndef CLOCK_POWER_CONSTS_VH
`define CLOCK_POWER_CONSTS_VH

// Register offsets
`define REG_POWER_MODE       13'h0008
`define REG_DUTY_CONTROL     13'h0009
`define REG_CLOCK_DIVIDE     13'h000b
`define REG_CLOCK_STATUS     13'h000c
`define REG_FULL_SCALE_TRIM  13'h0018
`define REG_REALIGN_CONTROL  13'h003a

// Field positions
`define PM_MODE_MSB          1
`define PM_MODE_LSB          0
`define TRIM_MSB             4
`define DCS_ENABLE_BIT       0
`define DIVIDE_MSB           2
`define REALIGN_ENABLE_BIT   1
`define REALIGN_FIRST_BIT    2
`define STAT_LOCKED_BIT      0
`define STAT_ARMED_BIT       1
`define STAT_POWERDOWN_BIT   2
`define STAT_STANDBY_BIT     3

// Power mode encodings
`define PM_NORMAL            2'h0
`define PM_POWERDOWN         2'h1
`define PM_STANDBY           2'h2

// Reset values
`define RST_POWER_MODE       8'h00
`define RST_DUTY_CONTROL     8'h01
`define RST_CLOCK_DIVIDE     8'h00
`define RST_FULL_SCALE_TRIM  8'h00
`define RST_REALIGN_CONTROL  8'h00

// Serial port framing
`define SPI_INSTR_BITS       5'h0f
`define SPI_LAST_BIT         5'h17
`define SPI_RW_BIT           15

// Timing
`define SYS_CLK_PERIOD_NS    5
`define SYS_CLK_MHZ          200
`define DCS_MIN_RATE_MHZ     20
`define DCS_RELOCK_NS        5000
`define DCS_RELOCK_CYCLES    (`DCS_RELOCK_NS / `SYS_CLK_PERIOD_NS)

`endif

// ==== src/align_sync.v ====
// Align input synchronizer and rising-edge detector
`timescale 1ns/100ps
module align_sync
(
    // Clock and reset
    input  wire  sys_clk,
    input  wire  arst_n,
    // Align pin and detected edge
    input  wire  align_in,
    output reg   align_rise
);

reg meta_reg;
reg sync_reg;
reg last_reg;

always @(posedge sys_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        meta_reg   <= 1'b0;
        sync_reg   <= 1'b0;
        last_reg   <= 1'b0;
        align_rise <= 1'b0;
    end
    else
    begin
        meta_reg   <= align_in;
        sync_reg   <= meta_reg;
        last_reg   <= sync_reg;
        align_rise <= sync_reg & ~last_reg;
    end
end

endmodule // align_sync

// ==== src/clock_div.v ====
// Integer sample clock divider with duty-cycle stabilized output
`timescale 1ns/100ps
module clock_div
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        arst_n,
    // Control
    input  wire [2:0]  ratio_m1,
    input  wire        dcs_active,
    input  wire        realign,
    input  wire        run,
    // Conversion clock
    output reg         conv_en,
    output reg         conv_clk
);

reg  [2:0] count_reg;
reg  [2:0] count_next;
wire [3:0] high_len;

// High phase length: half the period rounded up
assign high_len = ({1'b0, ratio_m1} + 4'h2) >> 1;

always @*
begin
    if (!run || realign)
        count_next = 3'h0;
    else if (count_reg >= ratio_m1)
        count_next = 3'h0;
    else
        count_next = count_reg + 3'h1;
end

always @(posedge sys_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        count_reg <= 3'h0;
        conv_en   <= 1'b0;
        conv_clk  <= 1'b0;
    end
    else
    begin
        count_reg <= count_next;
        conv_en   <= run && (count_next == 3'h0);
        if (!run)
            conv_clk <= 1'b0;
        else if (dcs_active)
            conv_clk <= ({1'b0, count_next} < high_len);
        else
            conv_clk <= (count_next == 3'h0);
    end
end

endmodule // clock_div

// ==== src/clock_power_ctrl.v ====
// Clock divider, realign, power mode and trim control with serial port
// Operation
// - Hold five-bit full-scale trim code in low bits of full_scale_trim.
// - Divide sample clock by programmable integer ratio 1 to 8.
// - Two bits at 0x3a select realign on every or first pulse.
// - Accepted align pulse returns divider counter to initial state.
// - Align input passes through sample clock synchronizer first.
// - Enabled stabilizer regenerates falling edge for nominal 50% duty.
// - Stabilizer is not relied on below about 20 MHz.
// - After frequency change, stabilizer bypassed until relock time passes.
// - Power-down when mode field selects it or pin is high.
// - Output drivers go high-impedance in power-down.
// - Pin low returns to normal unless field requests low power.
// - Power-down shuts reference, buffer, bias and internal clock.
// - Standby keeps reference powered and serial outputs running.
// - Capture each input sample on conversion clock rising edge.
`timescale 1ns/100ps
`include "clock_power_consts.vh"
module clock_power_ctrl
#(
    parameter SAMPLE_WIDTH = 14
)
(
    // Clock and reset
    input  wire                    sys_clk,
    input  wire                    arst_n,
    // Serial control port
    input  wire                    sclk,
    input  wire                    csb_n,
    input  wire                    sdio_in,
    output reg                     sdio_out,
    output reg                     sdio_oe_n,
    // Pins
    input  wire                    powerdown_pin,
    input  wire                    align_in,
    // Converter sample path
    input  wire [SAMPLE_WIDTH-1:0] adc_sample,
    output reg  [SAMPLE_WIDTH-1:0] sample_data,
    output reg                     sample_valid,
    // Conversion clock
    output reg                     conv_clk,
    // Analog and output control
    output reg  [4:0]              full_scale_code,
    output reg                     reference_enable,
    output reg                     ref_buffer_enable,
    output reg                     bias_enable,
    output reg                     serial_out_enable,
    output reg                     output_driver_oe_n
);

localparam integer RELOCK_INT = `DCS_RELOCK_CYCLES;
localparam [10:0] RELOCK_CYCLES = RELOCK_INT[10:0];
localparam integer MIN_RATE = `DCS_MIN_RATE_MHZ;
localparam integer CLK_RATE = `SYS_CLK_MHZ;

////////////////////////////////////////////////////////////////////////////
// Registers and serial port state

reg  [7:0]  power_mode_control_reg;
reg  [7:0]  duty_control_reg;
reg  [7:0]  clock_divide_reg;
reg  [7:0]  full_scale_trim_reg;
reg  [7:0]  divider_realign_control_reg;
reg         sclk_last_reg;
reg  [4:0]  bit_count_reg;
reg  [22:0] shift_in_reg;
reg  [15:0] instr_reg;
reg  [7:0]  read_shift_reg;
reg         realign_write_reg;
reg         divide_change_reg;
reg         armed_reg;
reg  [10:0] relock_count_reg;
reg         dcs_enable_last_reg;
reg  [7:0]  read_data;

wire        sclk_rise;
wire        sclk_fall;
wire [12:0] next_addr;
wire [23:0] frame_word;
wire        is_read;
wire        power_down;
wire        standby;
wire        run;
wire        rate_ok;
wire        dcs_locked;
wire        dcs_active;
wire        align_rise;
wire        align_accept;
wire        conv_en;
wire        conv_clk_int;
wire [1:0]  mode;

assign sclk_rise  = sclk & ~sclk_last_reg;
assign sclk_fall  = ~sclk & sclk_last_reg;
assign next_addr  = {shift_in_reg[11:0], sdio_in};
assign frame_word = {shift_in_reg, sdio_in};
assign is_read    = instr_reg[`SPI_RW_BIT];

////////////////////////////////////////////////////////////////////////////
// Read multiplexer

always @*
begin
    read_data = 8'h00;
    case (next_addr)
        `REG_POWER_MODE:      read_data = power_mode_control_reg;
        `REG_DUTY_CONTROL:    read_data = duty_control_reg;
        `REG_CLOCK_DIVIDE:    read_data = clock_divide_reg;
        `REG_FULL_SCALE_TRIM: read_data = full_scale_trim_reg;
        `REG_REALIGN_CONTROL: read_data = divider_realign_control_reg;
        `REG_CLOCK_STATUS:
        begin
            read_data[`STAT_LOCKED_BIT]    = dcs_locked;
            read_data[`STAT_ARMED_BIT]     = armed_reg;
            read_data[`STAT_POWERDOWN_BIT] = power_down;
            read_data[`STAT_STANDBY_BIT]   = standby;
        end
        default:              read_data = 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// Serial control port: 16-bit instruction then 8 data bits, MSB first

always @(posedge sys_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        sclk_last_reg               <= 1'b0;
        bit_count_reg               <= 5'h00;
        shift_in_reg                <= 23'h000000;
        instr_reg                   <= 16'h0000;
        read_shift_reg              <= 8'h00;
        sdio_out                    <= 1'b0;
        sdio_oe_n                   <= 1'b1;
        realign_write_reg           <= 1'b0;
        divide_change_reg           <= 1'b0;
        power_mode_control_reg      <= `RST_POWER_MODE;
        duty_control_reg            <= `RST_DUTY_CONTROL;
        clock_divide_reg            <= `RST_CLOCK_DIVIDE;
        full_scale_trim_reg         <= `RST_FULL_SCALE_TRIM;
        divider_realign_control_reg <= `RST_REALIGN_CONTROL;
    end
    else
    begin
        sclk_last_reg     <= sclk;
        realign_write_reg <= 1'b0;
        divide_change_reg <= 1'b0;
        if (csb_n)
        begin
            bit_count_reg <= 5'h00;
            sdio_oe_n     <= 1'b1;
        end
        else if (sclk_rise)
        begin
            shift_in_reg  <= frame_word[22:0];
            bit_count_reg <= bit_count_reg + 5'h01;
            if (bit_count_reg == `SPI_INSTR_BITS)
            begin
                instr_reg      <= frame_word[15:0];
                read_shift_reg <= read_data;
            end
            if ((bit_count_reg == `SPI_LAST_BIT) && !is_read)
            begin
                case (instr_reg[12:0])
                    `REG_POWER_MODE:
                        power_mode_control_reg <= frame_word[7:0];
                    `REG_DUTY_CONTROL:
                        duty_control_reg <= frame_word[7:0];
                    `REG_CLOCK_DIVIDE:
                    begin
                        clock_divide_reg  <= frame_word[7:0];
                        divide_change_reg <= 1'b1;
                    end
                    `REG_FULL_SCALE_TRIM:
                        full_scale_trim_reg <= frame_word[7:0];
                    `REG_REALIGN_CONTROL:
                    begin
                        divider_realign_control_reg <= frame_word[7:0];
                        realign_write_reg <= 1'b1;
                    end
                    default:
                        realign_write_reg <= 1'b0;
                endcase
            end
        end
        else if (sclk_fall && is_read && (bit_count_reg > `SPI_INSTR_BITS)
                 && (bit_count_reg <= `SPI_LAST_BIT))
        begin
            sdio_out       <= read_shift_reg[7];
            sdio_oe_n      <= 1'b0;
            read_shift_reg <= {read_shift_reg[6:0], 1'b0};
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Power mode decode

assign mode       = power_mode_control_reg[`PM_MODE_MSB:`PM_MODE_LSB];
assign power_down = powerdown_pin ||
                    (mode == `PM_POWERDOWN) ||
                    (mode == 2'h3);
assign standby    = !power_down && (mode == `PM_STANDBY);
assign run        = !power_down;

always @(posedge sys_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        reference_enable   <= 1'b0;
        ref_buffer_enable  <= 1'b0;
        bias_enable        <= 1'b0;
        serial_out_enable  <= 1'b0;
        output_driver_oe_n <= 1'b1;
        full_scale_code    <= 5'h00;
    end
    else
    begin
        reference_enable   <= !power_down;
        ref_buffer_enable  <= !power_down;
        bias_enable        <= !power_down && !standby;
        serial_out_enable  <= !power_down;
        output_driver_oe_n <= power_down;
        full_scale_code    <= full_scale_trim_reg[`TRIM_MSB:0];
    end
end

////////////////////////////////////////////////////////////////////////////
// Duty-cycle stabilizer lock and rate qualification

assign rate_ok    = ((clock_divide_reg[`DIVIDE_MSB:0] + 1) * MIN_RATE)
                    <= CLK_RATE;
assign dcs_locked = (relock_count_reg == 11'h000);
// The configuring party keeps the stabilizer on for odd and 6/8 ratios
assign dcs_active = duty_control_reg[`DCS_ENABLE_BIT] && rate_ok &&
                    dcs_locked;

always @(posedge sys_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        relock_count_reg    <= RELOCK_CYCLES;
        dcs_enable_last_reg <= 1'b0;
    end
    else
    begin
        dcs_enable_last_reg <= duty_control_reg[`DCS_ENABLE_BIT];
        if (divide_change_reg || power_down ||
            (duty_control_reg[`DCS_ENABLE_BIT] && !dcs_enable_last_reg))
            relock_count_reg <= RELOCK_CYCLES;
        else if (!dcs_locked)
            relock_count_reg <= relock_count_reg - 11'h001;
    end
end

////////////////////////////////////////////////////////////////////////////
// Align pulse qualification

assign align_accept = align_rise &&
                      divider_realign_control_reg[`REALIGN_ENABLE_BIT] &&
                      (!divider_realign_control_reg[`REALIGN_FIRST_BIT] ||
                       armed_reg);

// Rewrite arms again even if a pulse lands in the same cycle
always @(posedge sys_clk or negedge arst_n)
begin
    if (!arst_n)
        armed_reg <= 1'b0;
    else if (realign_write_reg)
        armed_reg <= 1'b1;
    else if (align_accept)
        armed_reg <= 1'b0;
end

align_sync u_align_sync
(
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .align_in   (align_in),
    .align_rise (align_rise)
);

clock_div u_clock_div
(
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .ratio_m1   (clock_divide_reg[`DIVIDE_MSB:0]),
    .dcs_active (dcs_active),
    .realign    (align_accept),
    .run        (run),
    .conv_en    (conv_en),
    .conv_clk   (conv_clk_int)
);

////////////////////////////////////////////////////////////////////////////
// Sample capture on conversion clock rising edge

always @(posedge sys_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        sample_data  <= {SAMPLE_WIDTH{1'b0}};
        sample_valid <= 1'b0;
        conv_clk     <= 1'b0;
    end
    else
    begin
        conv_clk     <= conv_clk_int;
        sample_valid <= conv_en;
        if (conv_en)
            sample_data <= adc_sample;
    end
end

endmodule // clock_power_ctrl

// ==== verification/clock_power_checks_assertions.sv ====
// Port assertions for the clock and power control block
`timescale 1ns/100ps
module clock_power_checks
(
    // Clock and reset
    input wire        sys_clk,
    input wire        arst_n,
    // Serial port
    input wire        csb_n,
    input wire        sdio_oe_n,
    // Pins and samples
    input wire        powerdown_pin,
    input wire [13:0] adc_sample,
    input wire [13:0] sample_data,
    input wire        sample_valid,
    input wire        conv_clk,
    // Power outputs
    input wire        reference_enable,
    input wire        ref_buffer_enable,
    input wire        bias_enable,
    input wire        serial_out_enable,
    input wire        output_driver_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    pd_pin_a: assert property (
        powerdown_pin [*3] |-> output_driver_oe_n)
        else $error("pin held high but drivers still on");
    pd_shutoff_a: assert property (
        output_driver_oe_n |-> !(reference_enable || ref_buffer_enable
        || bias_enable)) else $error("supply kept on in power-down");
    pd_clock_a: assert property (
        output_driver_oe_n [*3] |-> !conv_clk && !sample_valid)
        else $error("clock runs in power-down");
    standby_keep_a: assert property (
        serial_out_enable && !bias_enable |-> reference_enable
        && ref_buffer_enable) else $error("standby lost reference");
    normal_drive_a: assert property (
        bias_enable |-> !output_driver_oe_n)
        else $error("drivers off in normal mode");
    capture_a: assert property (
        sample_valid |-> sample_data == $past(adc_sample))
        else $error("sample not taken at clock rise");
    valid_edge_a: assert property (
        sample_valid |-> conv_clk) else $error("valid without clock");
    rise_valid_a: assert property (
        $rose(conv_clk) |-> sample_valid)
        else $error("clock rise without sample");
    sdio_free_a: assert property (
        csb_n [*2] |-> sdio_oe_n) else $error("data line held");
endmodule // clock_power_checks

bind clock_power_ctrl clock_power_checks checks (.sys_clk(sys_clk),
    .arst_n(arst_n), .csb_n(csb_n), .sdio_oe_n(sdio_oe_n),
    .powerdown_pin(powerdown_pin), .adc_sample(adc_sample),
    .sample_data(sample_data), .sample_valid(sample_valid),
    .conv_clk(conv_clk), .reference_enable(reference_enable),
    .ref_buffer_enable(ref_buffer_enable), .bias_enable(bias_enable),
    .serial_out_enable(serial_out_enable),
    .output_driver_oe_n(output_driver_oe_n));

// ==== verification/align_source.sv ====
// Far-side model: align pulse driver and converter data source
`timescale 1ns/100ps
module align_source
(
    // Clock
    input  wire        sys_clk,
    // Request from the bench
    input  wire        fire,
    // Far-side pins
    output reg         align_in = 1'b0,
    output reg  [13:0] adc_sample = 14'h0000
);
    reg [1:0] hold_reg = 2'h0;
    // Pulse launched on the input clock edge, three cycles long
    always @(posedge sys_clk)
    begin
        adc_sample <= adc_sample + 14'h0b3d;
        hold_reg   <= fire ? 2'h2 : hold_reg - {1'b0, hold_reg != 2'h0};
        align_in   <= fire || hold_reg != 2'h0;
    end
endmodule // align_source

// ==== verification/sample_clock_divider_power_control_tb.sv ====
// Testbench for the clock and power control block
`timescale 1ns/100ps
module sample_clock_divider_power_control_tb;
    logic        sys_clk = 0, arst_n = 0, sclk = 0, csb_n = 1;
    logic        sdio_in = 0, powerdown_pin = 0, fire = 0;
    wire         sdio_out, sdio_oe_n, align_in, sample_valid, conv_clk;
    wire  [13:0] adc_sample, sample_data;
    wire  [4:0]  full_scale_code;
    wire         reference_enable, ref_buffer_enable, bias_enable;
    wire         serial_out_enable, output_driver_oe_n;
    int          bad_count = 0, check_count = 0, cyc = 0;

    clock_power_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .sclk(sclk),
        .csb_n(csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n), .powerdown_pin(powerdown_pin),
        .align_in(align_in), .adc_sample(adc_sample),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .conv_clk(conv_clk), .full_scale_code(full_scale_code),
        .reference_enable(reference_enable),
        .ref_buffer_enable(ref_buffer_enable), .bias_enable(bias_enable),
        .serial_out_enable(serial_out_enable),
        .output_driver_oe_n(output_driver_oe_n));
    align_source far (.sys_clk(sys_clk), .fire(fire), .align_in(align_in),
        .adc_sample(adc_sample));

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            bad_count++;
            tally_and_finish;
        end
    end
    //////////////////////////////////////////////////////////////////////
    task tk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    // One serial frame, MSB first; read bits sampled before each rise
    task rd(input logic [12:0] a, output logic [7:0] q, input logic w = 0,
        input logic [7:0] d = 0);
        logic [23:0] f;
        f = {~w, 2'b00, a, d};
        csb_n <= 0;
        for (int i = 23; i >= 0; i--)
        begin
            sdio_in <= f[i];
            tk(4);
            if (i < 8) q[i] = sdio_out;
            sclk <= 1;
            tk(4);
            sclk <= 0;
        end
        tk(4);
        csb_n <= 1;
        tk(3);
    endtask
    task wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        rd(a, q, 1, d);
    endtask
    task rdc(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        check({8'h0, q}, {8'h0, e});
    endtask
    // Expected {reference, buffer, bias, serial, drivers off}
    task pw(input logic [4:0] e);
        tk(3);
        check({11'h0, reference_enable, ref_buffer_enable, bias_enable,
            serial_out_enable, output_driver_oe_n}, {11'h0, e});
    endtask
    task cc(output int hi, output int per);
        do tk(1); while (sample_valid !== 1'b1);
        hi = 0;
        per = 0;
        do
        begin
            hi += (conv_clk === 1'b1);
            per++;
            tk(1);
        end while (sample_valid !== 1'b1);
    endtask
    // Align pulse three cycles past a multiple of eight from ref0
    task pulse(input int ref0, output int p, output int r);
        while ((cyc - ref0) % 8 != 3) tk(1);
        fire <= 1;
        tk(1);
        fire <= 0;
        p = cyc;
        tk(12);
        do tk(1); while (sample_valid !== 1'b1);
        r = cyc;
    endtask
    //////////////////////////////////////////////////////////////////////
    task t_reset;
        pw(5'h1e);
        rdc(13'h008, 8'h00);
        rdc(13'h009, 8'h01);
        rdc(13'h03a, 8'h00);
        wr(13'h055, 8'ha5);
        rdc(13'h055, 8'h00);
        wr(13'h018, 8'hb5);
        check({11'h0, full_scale_code}, 16'h0015);
        rdc(13'h018, 8'hb5);
    endtask
    task t_div;
        int hi, per, n;
        for (int r = 2; r <= 8; r++)
        begin
            wr(13'h00b, 8'(r - 1));
            cc(hi, per);
            check(16'(per), 16'(r));
            check(16'(hi), 16'h1);
            tk(1000);
            cc(hi, per);
            check(16'(hi), 16'((r + 1) / 2));
        end
        wr(13'h00b, 8'h00);
        n = 0;
        repeat (8)
        begin
            tk(1);
            n += (conv_clk === 1'b1);
        end
        check(16'(n), 16'h8);
    endtask
    task t_align;
        int p0, r0, p1, r1, ph;
        logic [7:0] q;
        wr(13'h00b, 8'h07);
        wr(13'h03a, 8'h02);
        pulse(cyc, p0, r0);
        ph = (r0 - p0) % 8;
        check(16'(ph), 16'h6);
        pulse(p0, p1, r1);
        check(16'((r1 - p1) % 8), 16'(ph));
        wr(13'h03a, 8'h06);
        rd(13'h00c, q);
        check({15'h0, q[1]}, 16'h1);
        pulse(p1, p0, r0);
        check(16'((r0 - p0) % 8), 16'(ph));
        rd(13'h00c, q);
        check({15'h0, q[1]}, 16'h0);
        pulse(p0, p1, r1);
        check(16'((r1 - p0) % 8), 16'(ph));
        wr(13'h03a, 8'h00);
        pulse(p0, p1, r1);
        check(16'((r1 - p0) % 8), 16'(ph));
    endtask
    task t_power;
        logic [4:0] tab [4] = '{5'h1e, 5'h01, 5'h1a, 5'h01};
        powerdown_pin <= 1;
        pw(5'h01);
        powerdown_pin <= 0;
        pw(5'h1e);
        for (int m = 0; m < 4; m++)
        begin
            wr(13'h008, 8'(m));
            pw(tab[m]);
        end
        wr(13'h008, 8'h02);
        powerdown_pin <= 1;
        pw(5'h01);
        powerdown_pin <= 0;
        pw(5'h1a);
        wr(13'h008, 8'h00);
        pw(5'h1e);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        tk(5);
        arst_n <= 1;
        tk(2);
        t_reset;
        t_div;
        t_align;
        t_power;
        tally_and_finish;
    end
endmodule // sample_clock_divider_power_control_tb
